// file: verilog/bmw_decode.sv
// Functional notes
// - memory base field gives address bits 31:20
// - memory limit field, low bits all ones
// - memory registers read zero low nibble
// - forward when address in memory window
// - prefetch base field gives address bits 31:20
// - prefetch limit field, low bits all ones
// - forward when address in prefetch window
// - upper base register supplies bits 63:32
// - upper limit register supplies bits 63:32
// - prefetch low nibble reads one, reset 0001h
// - memory base and limit reset zero
// - upper registers writable, reset zero
`timescale 1ns/1ps
module bmw_decode (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire bmw_pkg::bmw_cfg_req_type i_cfg,
	input  wire bmw_pkg::bmw_txn_type     i_txn,
	output logic [31:0]                   o_rdata,
	output logic                          o_rvalid,
	output logic                          o_fwd_valid,
	output logic                          o_fwd_mem,
	output logic                          o_fwd_prefetch
);
	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [11:0] memory_window_base_field;
	logic [11:0] memory_window_limit_field;
	logic [11:0] prefetch_window_base_field;
	logic [11:0] prefetch_window_limit_field;
	logic [31:0] prefetch_upper_base;
	logic [31:0] prefetch_upper_limit;
	logic [15:0] memory_window_low_bound;
	logic [15:0] memory_window_high_bound;
	logic [15:0] prefetch_window_low_bound;
	logic [15:0] prefetch_window_high_bound;
	logic [63:0] mem_low_addr;
	logic [63:0] mem_high_addr;
	logic [63:0] pf_low_addr;
	logic [63:0] pf_high_addr;
	logic        mem_hit;
	logic        pf_hit;
	logic [31:0] next_rdata;
	logic [7:0]  word_addr;
	logic        wr_word_20;
	logic        wr_word_24;

	// ---------------------------------------------------------------
	// layout check
	// ---------------------------------------------------------------
	if (bmw_pkg::FIELD_LSB + bmw_pkg::FIELD_WIDTH != 16
		|| bmw_pkg::FIELD_WIDTH + bmw_pkg::ADDR_LOW_BITS != 32) begin : g_bad_layout
		$error("field layout does not fit the window registers");
	end

	assign word_addr  = {i_cfg.addr[7:2], 2'b00};
	assign wr_word_20 = i_cfg.wr && (word_addr == bmw_pkg::MEM_LOW_OFFSET);
	assign wr_word_24 = i_cfg.wr && (word_addr == bmw_pkg::PF_LOW_OFFSET);

	// ---------------------------------------------------------------
	// configuration writes
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			memory_window_base_field  <= bmw_pkg::MEM_RESET[15:4];
			memory_window_limit_field <= bmw_pkg::MEM_RESET[15:4];
		end else begin
			if (wr_word_20 && i_cfg.byte_en[0]) begin
				memory_window_base_field[3:0] <= i_cfg.wdata[7:4];
			end
			if (wr_word_20 && i_cfg.byte_en[1]) begin
				memory_window_base_field[11:4] <= i_cfg.wdata[15:8];
			end
			if (wr_word_20 && i_cfg.byte_en[2]) begin
				memory_window_limit_field[3:0] <= i_cfg.wdata[23:20];
			end
			if (wr_word_20 && i_cfg.byte_en[3]) begin
				memory_window_limit_field[11:4] <= i_cfg.wdata[31:24];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prefetch_window_base_field  <= bmw_pkg::PF_RESET[15:4];
			prefetch_window_limit_field <= bmw_pkg::PF_RESET[15:4];
		end else begin
			if (wr_word_24 && i_cfg.byte_en[0]) begin
				prefetch_window_base_field[3:0] <= i_cfg.wdata[7:4];
			end
			if (wr_word_24 && i_cfg.byte_en[1]) begin
				prefetch_window_base_field[11:4] <= i_cfg.wdata[15:8];
			end
			if (wr_word_24 && i_cfg.byte_en[2]) begin
				prefetch_window_limit_field[3:0] <= i_cfg.wdata[23:20];
			end
			if (wr_word_24 && i_cfg.byte_en[3]) begin
				prefetch_window_limit_field[11:4] <= i_cfg.wdata[31:24];
			end
		end
	end

	// ---------------------------------------------------------------
	// upper 32-bit prefetch registers, one per byte lane
	// ---------------------------------------------------------------
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_upper
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					prefetch_upper_base[lane*8 +: 8]  <= bmw_pkg::UPPER_RESET[lane*8 +: 8];
					prefetch_upper_limit[lane*8 +: 8] <= bmw_pkg::UPPER_RESET[lane*8 +: 8];
				end else begin
					if (i_cfg.wr && i_cfg.byte_en[lane]
						&& word_addr == bmw_pkg::PF_UP_LOW_OFFSET) begin
						prefetch_upper_base[lane*8 +: 8] <= i_cfg.wdata[lane*8 +: 8];
					end
					if (i_cfg.wr && i_cfg.byte_en[lane]
						&& word_addr == bmw_pkg::PF_UP_HIGH_OFFSET) begin
						prefetch_upper_limit[lane*8 +: 8] <= i_cfg.wdata[lane*8 +: 8];
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// register read view
	// ---------------------------------------------------------------
	assign memory_window_low_bound    = {memory_window_base_field, bmw_pkg::MEM_LOW_NIBBLE};
	assign memory_window_high_bound   = {memory_window_limit_field, bmw_pkg::MEM_LOW_NIBBLE};
	assign prefetch_window_low_bound  = {prefetch_window_base_field, bmw_pkg::WIDE_INDICATOR};
	assign prefetch_window_high_bound = {prefetch_window_limit_field, bmw_pkg::WIDE_INDICATOR};

	always_comb begin
		case (word_addr)
			bmw_pkg::MEM_LOW_OFFSET:    next_rdata = {memory_window_high_bound,
			                                          memory_window_low_bound};
			bmw_pkg::PF_LOW_OFFSET:     next_rdata = {prefetch_window_high_bound,
			                                          prefetch_window_low_bound};
			bmw_pkg::PF_UP_LOW_OFFSET:  next_rdata = prefetch_upper_base;
			bmw_pkg::PF_UP_HIGH_OFFSET: next_rdata = prefetch_upper_limit;
			default:                    next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata  <= 32'h0000_0000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_cfg.rd;
			o_rdata  <= i_cfg.rd ? next_rdata : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// window bounds
	// ---------------------------------------------------------------
	assign mem_low_addr  = {32'h0000_0000, memory_window_base_field, bmw_pkg::LOW_BITS_ZERO};
	assign mem_high_addr = {32'h0000_0000, memory_window_limit_field, bmw_pkg::LOW_BITS_ONES};
	assign pf_low_addr   = {prefetch_upper_base, prefetch_window_base_field,
	                        bmw_pkg::LOW_BITS_ZERO};
	assign pf_high_addr  = {prefetch_upper_limit, prefetch_window_limit_field,
	                        bmw_pkg::LOW_BITS_ONES};

	bmw_window_cmp #(
		.WIDTH (64)
	) u_mem_cmp (
		.i_addr (i_txn.addr),
		.i_low  (mem_low_addr),
		.i_high (mem_high_addr),
		.o_hit  (mem_hit)
	);

	bmw_window_cmp #(
		.WIDTH (64)
	) u_pf_cmp (
		.i_addr (i_txn.addr),
		.i_low  (pf_low_addr),
		.i_high (pf_high_addr),
		.o_hit  (pf_hit)
	);

	// ---------------------------------------------------------------
	// forward decision
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_fwd_valid    <= 1'b0;
			o_fwd_mem      <= 1'b0;
			o_fwd_prefetch <= 1'b0;
		end else begin
			o_fwd_valid    <= i_txn.valid;
			o_fwd_mem      <= i_txn.valid && mem_hit;
			o_fwd_prefetch <= i_txn.valid && pf_hit;
		end
	end

endmodule : bmw_decode

// file: verilog/bmw_pkg.sv
package bmw_pkg;

	// ---------------------------------------------------------------
	// configuration offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] MEM_LOW_OFFSET  = 8'h20;
	localparam logic [7:0] MEM_HIGH_OFFSET = 8'h22;
	localparam logic [7:0] PF_LOW_OFFSET   = 8'h24;
	localparam logic [7:0] PF_HIGH_OFFSET  = 8'h26;
	localparam logic [7:0] PF_UP_LOW_OFFSET  = 8'h28;
	localparam logic [7:0] PF_UP_HIGH_OFFSET = 8'h2C;

	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam int          FIELD_LSB        = 4;
	localparam int          FIELD_WIDTH      = 12;
	localparam int          ADDR_LOW_BITS    = 20;
	localparam logic [3:0]  MEM_LOW_NIBBLE   = 4'h0;
	localparam logic [3:0]  WIDE_INDICATOR   = 4'h1;
	localparam logic [15:0] MEM_RESET        = 16'h0000;
	localparam logic [15:0] PF_RESET         = 16'h0001;
	localparam logic [31:0] UPPER_RESET      = 32'h0000_0000;
	localparam logic [19:0] LOW_BITS_ZERO    = 20'h0_0000;
	localparam logic [19:0] LOW_BITS_ONES    = 20'hF_FFFF;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} bmw_cfg_req_type;

	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
	} bmw_txn_type;

endpackage : bmw_pkg

// file: verilog/bmw_window_cmp.sv
`timescale 1ns/1ps
module bmw_window_cmp #(
	parameter int WIDTH = 64
) (
	input  wire logic [WIDTH-1:0] i_addr,
	input  wire logic [WIDTH-1:0] i_low,
	input  wire logic [WIDTH-1:0] i_high,
	output logic                  o_hit
);
	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	if (WIDTH < 32) begin : g_bad_width
		$error("window width too small");
	end

	// ---------------------------------------------------------------
	// inclusive compare, empty when high is below low
	// ---------------------------------------------------------------
	assign o_hit = (i_high >= i_low) && (i_addr >= i_low) && (i_addr <= i_high);

endmodule : bmw_window_cmp

// file: bench/bmw_decode_assertions.sv
`timescale 1ns/1ps
module bmw_decode_assertions (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire bmw_pkg::bmw_cfg_req_type i_cfg,
	input  wire bmw_pkg::bmw_txn_type     i_txn,
	input  wire logic [31:0]              o_rdata,
	input  wire logic                     o_rvalid,
	input  wire logic                     o_fwd_valid,
	input  wire logic                     o_fwd_mem,
	input  wire logic                     o_fwd_prefetch
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_read_answer: assert property (i_cfg.rd |=> o_rvalid)
		else $error("read not answered");
	chk_no_stray_answer: assert property (!i_cfg.rd |=> !o_rvalid)
		else $error("answer without read");
	chk_rdata_idle_zero: assert property (!o_rvalid |-> o_rdata == 32'h0000_0000)
		else $error("read data while idle");
	chk_mem_nibble_zero: assert property (o_rvalid && $past(i_cfg.addr[7:2]) == 6'h08
		|-> o_rdata[3:0] == 4'h0 && o_rdata[19:16] == 4'h0)
		else $error("memory low nibble not zero");
	chk_pf_nibble_one: assert property (o_rvalid && $past(i_cfg.addr[7:2]) == 6'h09
		|-> o_rdata[3:0] == 4'h1 && o_rdata[19:16] == 4'h1)
		else $error("prefetch low nibble not one");
	chk_fwd_follows: assert property (1'b1 |=> o_fwd_valid == $past(i_txn.valid))
		else $error("forward valid not a copy");
	chk_fwd_needs_valid: assert property (!i_txn.valid |=> !o_fwd_mem && !o_fwd_prefetch)
		else $error("forward without request");
	chk_mem_upper_zero: assert property (i_txn.valid && i_txn.addr[63:32] != 32'h0000_0000
		|=> !o_fwd_mem)
		else $error("memory hit above 4G");
endmodule : bmw_decode_assertions

bind bmw_decode bmw_decode_assertions u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
	.i_txn(i_txn), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_fwd_valid(o_fwd_valid),
	.o_fwd_mem(o_fwd_mem), .o_fwd_prefetch(o_fwd_prefetch));

// file: bench/bmw_up_host.sv
`timescale 1ns/1ps
module bmw_up_host (
	input  wire logic           i_clk,
	output bmw_pkg::bmw_txn_type o_txn
);
	initial o_txn = '0;
	// upstream request, one cycle, then released with inverted address
	task automatic issue(input logic [63:0] a);
		@(negedge i_clk);
		o_txn = '{valid: 1'b1, addr: a};
		@(negedge i_clk);
		o_txn = '{valid: 1'b0, addr: ~a};
	endtask : issue
endmodule : bmw_up_host

// file: bench/bmw_decode_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bmw_decode_tb_top;
	logic                     i_clk;
	logic                     i_rst_n;
	bmw_pkg::bmw_cfg_req_type i_cfg;
	bmw_pkg::bmw_txn_type     i_txn;
	logic [31:0]              o_rdata;
	logic                     o_rvalid;
	logic                     o_fwd_valid;
	logic                     o_fwd_mem;
	logic                     o_fwd_prefetch;
	int                       err_total = 0;
	int                       tests_run = 0;
	int                       cycles = 0;

	bmw_decode DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg), .i_txn(i_txn),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_fwd_valid(o_fwd_valid),
		.o_fwd_mem(o_fwd_mem), .o_fwd_prefetch(o_fwd_prefetch));
	bmw_up_host u_host (.i_clk(i_clk), .o_txn(i_txn));

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(negedge i_clk);
		i_cfg = '{1'b1, 1'b0, a, be, d};
		@(negedge i_clk);
		i_cfg = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge i_clk);
		i_cfg = '{1'b0, 1'b1, a, 4'hF, 32'h0000_0000};
		@(negedge i_clk);
		i_cfg = '0;
		`CHK(o_rvalid, 1'b1)
		`CHK(o_rdata, e)
	endtask : rd
	task automatic probe(input logic [63:0] a, input logic m, input logic p);
		u_host.issue(a);
		`CHK({o_fwd_valid, o_fwd_mem, o_fwd_prefetch}, {1'b1, m, p})
	endtask : probe
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_cfg = '0;
		repeat (8) @(negedge i_clk);
		i_rst_n = 1'b1;
		rd(8'h20, 32'h0000_0000);
		rd(8'h24, 32'h0001_0001);
		rd(8'h28, 32'h0000_0000);
		rd(8'h2C, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000);
		probe(64'h0000_0000_000F_FFFF, 1'b1, 1'b1);
		probe(64'h0000_0000_0010_0000, 1'b0, 1'b0);
		wr(8'h20, 32'h0030_0021, 4'hF);
		rd(8'h20, 32'h0030_0020);
		probe(64'h0000_0000_0020_0000, 1'b1, 1'b0);
		probe(64'h0000_0000_001F_FFFF, 1'b0, 1'b0);
		probe(64'h0000_0000_003F_FFFF, 1'b1, 1'b0);
		probe(64'h0000_0001_0020_0000, 1'b0, 1'b0);
		wr(8'h24, 32'h005E_004F, 4'hF);
		rd(8'h24, 32'h0051_0041);
		wr(8'h28, 32'h0000_0002, 4'hF);
		wr(8'h2C, 32'h0000_0003, 4'hF);
		rd(8'h28, 32'h0000_0002);
		rd(8'h2C, 32'h0000_0003);
		probe(64'h0000_0002_0040_0000, 1'b0, 1'b1);
		probe(64'h0000_0002_003F_FFFF, 1'b0, 1'b0);
		probe(64'h0000_0003_005F_FFFF, 1'b0, 1'b1);
		probe(64'h0000_0003_0060_0000, 1'b0, 1'b0);
		probe(64'h0000_0002_FFFF_FFFF, 1'b0, 1'b1);
		wr(8'h20, 32'hFFFF_FFFF, 4'h3);
		rd(8'h20, 32'h0030_FFF0);
		probe(64'h0000_0000_0030_0000, 1'b0, 1'b0);
		end_sim();
	end
endmodule : bmw_decode_tb_top
